// ===== hdl/sync_check_pkg.sv
// Shared constants for the check-synchronism permit block
package sync_check_pkg;

   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ANGLE = 8'h04;
   localparam logic [7:0] OFS_UNDERV = 8'h08;
   localparam logic [7:0] OFS_DIFFV = 8'h0c;
   localparam logic [7:0] OFS_SLIPF = 8'h10;
   localparam logic [7:0] OFS_SLIPT = 8'h14;
   localparam logic [7:0] OFS_LIVEV = 8'h18;
   localparam logic [7:0] OFS_DEADV = 8'h1c;
   localparam logic [7:0] OFS_STATUS = 8'h20;
   localparam logic [7:0] OFS_CHKMAG = 8'h24;
   localparam logic [7:0] OFS_CHKANG = 8'h28;
   localparam logic [7:0] OFS_ANGDIFF = 8'h2c;
   localparam logic [7:0] OFS_SLIPMEAS = 8'h30;

   // ---------------------------------------------------------------
   // Control register fields
   // ---------------------------------------------------------------
   localparam int CTRL_SYNC_EN = 0;
   localparam int CTRL_SIDE = 1;
   localparam int CTRL_INSEL_LO = 2;
   localparam int CTRL_VBLK_LO = 5;
   localparam int CTRL_SLIP_LO = 7;
   localparam int CTRL_IMMED = 9;
   localparam int CTRL_MAN_LO = 10;
   localparam int CTRL_AR_LO = 14;
   localparam int CTRL_BITS = 18;
   // Enable set order within a path: {deadDead, liveLineDeadBus, deadLineLiveBus, checkSync}
   localparam int EN_CS = 0;
   localparam int EN_DLLB = 1;
   localparam int EN_LLDB = 2;
   localparam int EN_DLDB = 3;

   // ---------------------------------------------------------------
   // Reset values (voltages 0.1 V, angle 0.1 deg, slip mHz, timer 0.1 s)
   // ---------------------------------------------------------------
   localparam logic [31:0] CTRL_RESET = 32'h0001dd21;
   localparam logic [15:0] ANGLE_RESET = 16'h00c8;
   localparam logic [15:0] UNDERV_RESET = 16'h021c;
   localparam logic [15:0] DIFFV_RESET = 16'h0041;
   localparam logic [15:0] SLIPF_RESET = 16'h0032;
   localparam logic [15:0] SLIPT_RESET = 16'h000a;
   localparam logic [15:0] LIVEV_RESET = 16'h0140;
   localparam logic [15:0] DEADV_RESET = 16'h0082;

   // ---------------------------------------------------------------
   // Angle arithmetic and timing
   // ---------------------------------------------------------------
   localparam logic signed [13:0] HALF_TURN = 14'sh0708;
   localparam logic signed [13:0] FULL_TURN = 14'sh0e10;
   localparam int CLK_PERIOD_NS = 25;
   localparam int TIMER_STEP_NS = 100_000_000;
   localparam int TIMER_STEP_CYCLES = TIMER_STEP_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      VBLK_NONE = 2'b00,
      VBLK_UNDER = 2'b01,
      VBLK_DIFF = 2'b10,
      VBLK_EITHER = 2'b11
   } volt_block_e;

   typedef enum logic [1:0] {
      SLIP_NONE = 2'b00,
      SLIP_TIMER = 2'b01,
      SLIP_FREQ = 2'b10,
      SLIP_BOTH = 2'b11
   } slip_mode_e;

endpackage

// ===== hdl/step_divider.sv
// Divider giving a one-cycle enable every timer step
`timescale 1ns/1ps
module step_divider
   import sync_check_pkg::*;
#(
   parameter int STEP_CYCLES = TIMER_STEP_CYCLES
) (
   input wire logic sys_clk,
   input wire logic nrst,
   output logic stepTick
);
   generate
      if (STEP_CYCLES < 2) begin : g_bad
         $error("step_divider: STEP_CYCLES must be at least 2");
      end
   endgenerate

   logic [31:0] count_q;
   wire logic atEnd = (count_q == 32'(STEP_CYCLES - 1));

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         count_q <= 32'h0;
      end else begin
         count_q <= atEnd ? 32'h0 : count_q + 32'h1;
      end
   end

   assign stepTick = atEnd;

   chk_tick_spacing: assert property (@(posedge sys_clk) disable iff (!nrst)
      stepTick |=> !stepTick) else $error("step tick longer than one cycle");
endmodule // step_divider

// ===== hdl/hold_timer.sv
// Counts timer steps while the angle stays inside its window
`timescale 1ns/1ps
module hold_timer #(
   parameter int CNT_W = 10
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic stepTick,
   input wire logic hold,
   input wire logic [CNT_W-1:0] limit,
   output logic done
);
   generate
      if (CNT_W < 4 || CNT_W > 16) begin : g_bad
         $error("hold_timer: CNT_W out of range");
      end
   endgenerate

   logic [CNT_W-1:0] count_q;
   wire logic reached = (count_q >= limit);

   // Any break in the hold restarts the count, so a longer limit narrows the slip accepted
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         count_q <= '0;
      end else if (!hold) begin
         count_q <= '0;
      end else if (stepTick && !reached) begin
         count_q <= count_q + 1'b1;
      end
   end

   assign done = hold && reached;

   chk_done_needs_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
      (done && limit != '0) |-> $past(hold)) else $error("timer done without prior hold");
endmodule // hold_timer

// ===== hdl/check_sync_reclose_permit.sv
// Check-synchronism permit logic with its register port
`timescale 1ns/1ps
// How it works
// - Separate manual and autoreclose permit outputs
// - Checks disabled means manual and system-check permits asserted unless sensor fails
// - Each path has its own enable set
// - Voltage blocking: none, undervoltage, difference, either
// - Frequency mode permits at once below slip limit
// - Timer mode needs angle held for timer
// - Combined mode needs slip and timed angle
// - Longer timer narrows the slip accepted
// - Live and dead from separate thresholds
// - Dead side skips sync, uses combination enable
// - Sensor side routes main/check to line/bus
// - Six check input codes pick main quantity
// - Sensor failure forces permits inactive
// - Check magnitude, angle, difference, slip readable
// - Merge internal and external into two permits
// - Second permit needs sync and immediate option
// - Live when not below, dead when below
module check_sync_reclose_permit
   import sync_check_pkg::*;
#(
   parameter int STEP_CYCLES = TIMER_STEP_CYCLES,
   parameter int TIMER_W = 10
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData,
   input wire logic [5:0][15:0] mainMag,
   input wire logic [5:0][11:0] mainAng,
   input wire logic [15:0] checkMag,
   input wire logic [11:0] checkAng,
   input wire logic [15:0] slipMeas,
   input wire logic syncCheckEnableIn,
   input wire logic voltage_sensor_failure,
   input wire logic manualCloseReq,
   input wire logic external_sync_ok_input,
   input wire logic externalSysCheckOk,
   output logic manualPermit,
   output logic manualCloseGo,
   output logic arSysCheckOk,
   output logic arImmediateOk,
   output logic lineLive,
   output logic lineDead,
   output logic busLive,
   output logic busDead
);
   // ---------------------------------------------------------------
   // Setting registers
   // ---------------------------------------------------------------
   logic [CTRL_BITS-1:0] ctrl_q;
   logic [15:0] angleThr_q, underV_q, diffV_q, slipLim_q, slipTime_q, liveV_q, deadV_q;
   logic [31:0] rdData_q;

   wire logic wrCtrl = regWrite && regAddr == OFS_CTRL;
   wire logic wrAngle = regWrite && regAddr == OFS_ANGLE;
   wire logic wrUnderV = regWrite && regAddr == OFS_UNDERV;
   wire logic wrDiffV = regWrite && regAddr == OFS_DIFFV;
   wire logic wrSlipF = regWrite && regAddr == OFS_SLIPF;
   wire logic wrSlipT = regWrite && regAddr == OFS_SLIPT;
   wire logic wrLiveV = regWrite && regAddr == OFS_LIVEV;
   wire logic wrDeadV = regWrite && regAddr == OFS_DEADV;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ctrl_q <= CTRL_RESET[CTRL_BITS-1:0];
         angleThr_q <= ANGLE_RESET;
         underV_q <= UNDERV_RESET;
         diffV_q <= DIFFV_RESET;
         slipLim_q <= SLIPF_RESET;
         slipTime_q <= SLIPT_RESET;
         liveV_q <= LIVEV_RESET;
         deadV_q <= DEADV_RESET;
      end else begin
         if (wrCtrl) ctrl_q <= regWrData[CTRL_BITS-1:0];
         if (wrAngle) angleThr_q <= regWrData[15:0];
         if (wrUnderV) underV_q <= regWrData[15:0];
         if (wrDiffV) diffV_q <= regWrData[15:0];
         if (wrSlipF) slipLim_q <= regWrData[15:0];
         if (wrSlipT) slipTime_q <= regWrData[15:0];
         if (wrLiveV) liveV_q <= regWrData[15:0];
         if (wrDeadV) deadV_q <= regWrData[15:0];
      end
   end

   wire logic syncEnable = ctrl_q[CTRL_SYNC_EN] && syncCheckEnableIn;
   wire logic sensorOnBus = ctrl_q[CTRL_SIDE];
   wire logic [2:0] inputSel = ctrl_q[CTRL_INSEL_LO +: 3];
   wire volt_block_e voltBlock = volt_block_e'(ctrl_q[CTRL_VBLK_LO +: 2]);
   wire slip_mode_e slipMode = slip_mode_e'(ctrl_q[CTRL_SLIP_LO +: 2]);
   wire logic immediateOn = ctrl_q[CTRL_IMMED];
   wire logic [3:0] manEn = ctrl_q[CTRL_MAN_LO +: 4];
   wire logic [3:0] arEn = ctrl_q[CTRL_AR_LO +: 4];

   // ---------------------------------------------------------------
   // Quantity selection and angle difference
   // ---------------------------------------------------------------
   // Codes 0..2 phase-neutral, 3..5 phase-phase; codes 6 and 7 fall back to code 0
   wire logic [2:0] selIdx = (inputSel > 3'h5) ? 3'h0 : inputSel;
   wire logic [15:0] refMag = mainMag[selIdx];
   wire logic [11:0] refAng = mainAng[selIdx];

   wire logic [15:0] lineMag = sensorOnBus ? checkMag : refMag;
   wire logic [15:0] busMag = sensorOnBus ? refMag : checkMag;

   wire logic signed [13:0] rawDiff = 14'(signed'(checkAng)) - 14'(signed'(refAng));
   wire logic signed [13:0] wrapDiff = (rawDiff > HALF_TURN) ? rawDiff - FULL_TURN :
                                       (rawDiff < -HALF_TURN) ? rawDiff + FULL_TURN : rawDiff;
   wire logic [15:0] absDiff = 16'(wrapDiff < 0 ? -wrapDiff : wrapDiff);

   // ---------------------------------------------------------------
   // Live and dead classification
   // ---------------------------------------------------------------
   wire logic lineLiveW = lineMag >= liveV_q;
   wire logic lineDeadW = lineMag < deadV_q;
   wire logic busLiveW = busMag >= liveV_q;
   wire logic busDeadW = busMag < deadV_q;
   wire logic bothLive = lineLiveW && busLiveW;

   // ---------------------------------------------------------------
   // Synchronism conditions
   // ---------------------------------------------------------------
   wire logic [15:0] magGap = lineMag > busMag ? lineMag - busMag : busMag - lineMag;
   wire logic underBlk = !(lineMag > underV_q && busMag > underV_q);
   wire logic diffBlk = magGap >= diffV_q;
   wire logic voltBlocked = (voltBlock == VBLK_UNDER && underBlk) ||
                            (voltBlock == VBLK_DIFF && diffBlk) ||
                            (voltBlock == VBLK_EITHER && (underBlk || diffBlk));
   wire logic angleOk = absDiff < angleThr_q;
   wire logic freqOk = slipMeas < slipLim_q;
   wire logic baseOk = bothLive && angleOk && !voltBlocked;
   logic timerDone;
   logic stepTick;

   step_divider #(.STEP_CYCLES(STEP_CYCLES)) u_step (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .stepTick(stepTick)
   );

   // The hold window is twice the threshold, so slip accepted halves when the timer doubles
   hold_timer #(.CNT_W(TIMER_W)) u_hold (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .stepTick(stepTick),
      .hold(baseOk),
      .limit(slipTime_q[TIMER_W-1:0]),
      .done(timerDone)
   );

   logic syncOk;
   always_comb begin
      unique case (slipMode)
         SLIP_NONE: syncOk = baseOk;
         SLIP_TIMER: syncOk = timerDone;
         SLIP_FREQ: syncOk = baseOk && freqOk;
         SLIP_BOTH: syncOk = timerDone && freqOk;
      endcase
   end

   // ---------------------------------------------------------------
   // Permits per path
   // ---------------------------------------------------------------
   function automatic logic pathOk(input logic [3:0] en, input logic sOk, input logic lL, input logic lD,
                                   input logic bL, input logic bD);
      pathOk = (en[EN_CS] && sOk) || (en[EN_DLLB] && lD && bL) ||
               (en[EN_LLDB] && lL && bD) || (en[EN_DLDB] && lD && bD);
   endfunction

   // Failure wins over the disabled state: an unreliable voltage never opens a permit
   wire logic manOkW = !voltage_sensor_failure &&
      (!syncEnable || pathOk(manEn, syncOk, lineLiveW, lineDeadW, busLiveW, busDeadW));
   wire logic arOkW = !voltage_sensor_failure &&
      (!syncEnable || pathOk(arEn, syncOk, lineLiveW, lineDeadW, busLiveW, busDeadW));
   wire logic arCsW = syncEnable && arEn[EN_CS] && syncOk;
   wire logic arSysW = !voltage_sensor_failure && (arOkW || externalSysCheckOk);
   wire logic arImmW = !voltage_sensor_failure && immediateOn &&
                       (arCsW || external_sync_ok_input);

   // Only a fresh rising edge of the request can close; a held request never retries
   logic closeReqLast_q;
   wire logic closeEdge = manualCloseReq && !closeReqLast_q;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         closeReqLast_q <= 1'b0;
         manualPermit <= 1'b0;
         manualCloseGo <= 1'b0;
         arSysCheckOk <= 1'b0;
         arImmediateOk <= 1'b0;
         lineLive <= 1'b0;
         lineDead <= 1'b0;
         busLive <= 1'b0;
         busDead <= 1'b0;
      end else begin
         closeReqLast_q <= manualCloseReq;
         manualPermit <= manOkW;
         manualCloseGo <= closeEdge && manOkW;
         arSysCheckOk <= arSysW;
         arImmediateOk <= arImmW;
         lineLive <= lineLiveW;
         lineDead <= lineDeadW;
         busLive <= busLiveW;
         busDead <= busDeadW;
      end
   end

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   wire logic [31:0] statusWord = {24'h0, arImmediateOk, arSysCheckOk, manualPermit, syncOk,
                                   busDead, busLive, lineDead, lineLive};
   logic [31:0] rdMux;
   always_comb begin
      unique case (regAddr)
         OFS_CTRL: rdMux = 32'(ctrl_q);
         OFS_ANGLE: rdMux = {16'h0, angleThr_q};
         OFS_UNDERV: rdMux = {16'h0, underV_q};
         OFS_DIFFV: rdMux = {16'h0, diffV_q};
         OFS_SLIPF: rdMux = {16'h0, slipLim_q};
         OFS_SLIPT: rdMux = {16'h0, slipTime_q};
         OFS_LIVEV: rdMux = {16'h0, liveV_q};
         OFS_DEADV: rdMux = {16'h0, deadV_q};
         OFS_STATUS: rdMux = statusWord;
         OFS_CHKMAG: rdMux = {16'h0, checkMag};
         OFS_CHKANG: rdMux = {20'h0, checkAng};
         OFS_ANGDIFF: rdMux = {{18{wrapDiff[13]}}, wrapDiff};
         OFS_SLIPMEAS: rdMux = {16'h0, slipMeas};
         default: rdMux = 32'h0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         rdData_q <= 32'h0;
      end else begin
         rdData_q <= regRead ? rdMux : 32'h0;
      end
   end
   assign regRdData = rdData_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   chk_failure_blocks_permits: assert property (
      voltage_sensor_failure |=> !manualPermit && !arSysCheckOk && !arImmediateOk)
      else $error("permit active during sensor failure");
   chk_disabled_permit_high: assert property (
      (!syncEnable && !voltage_sensor_failure) |=> manualPermit && arSysCheckOk)
      else $error("disabled check did not assert permit");
   chk_freq_immediate_permit: assert property (
      (slipMode == SLIP_FREQ && syncEnable && manEn[EN_CS] && baseOk && freqOk && !voltage_sensor_failure)
      |=> manualPermit) else $error("frequency mode permit delayed");
   chk_timer_needs_hold: assert property (
      (slipMode == SLIP_TIMER && syncEnable && bothLive && !angleOk && manEn == 4'h1) |=> !manualPermit)
      else $error("timer mode permit with angle outside window");
   chk_both_needs_slip: assert property (
      (slipMode == SLIP_BOTH && syncEnable && !freqOk && manEn == 4'h1) |=> !manualPermit)
      else $error("combined mode permit with slip too high");
   chk_dead_combo_enable: assert property (
      (syncEnable && lineDeadW && busLiveW && !manEn[EN_DLLB]) |=> !manualPermit)
      else $error("dead line permit without its enable");
   chk_live_dead_flags: assert property (
      lineLive |-> !lineDead || (liveV_q < deadV_q)) else $error("line both live and dead");
   chk_close_single_shot: assert property (
      manualCloseGo |=> !manualCloseGo) else $error("held request closed twice");
   chk_immediate_option: assert property (
      !immediateOn |=> !arImmediateOk) else $error("immediate permit without option");
   chk_read_one_cycle: assert property (
      (regRead && regAddr == OFS_SLIPMEAS) |=> regRdData == {16'h0, $past(slipMeas)})
      else $error("slip read mismatch");
   chk_side_routing: assert property (
      (sensorOnBus && checkMag >= liveV_q && mainMag[selIdx] < deadV_q) |=> lineLive && busDead)
      else $error("sensor side routing wrong");
   chk_external_sys_check: assert property (
      (externalSysCheckOk && !voltage_sensor_failure) |=> arSysCheckOk)
      else $error("external system check ignored");
   chk_undervoltage_blocks: assert property (
      (syncEnable && manEn == 4'h1 && voltBlock == VBLK_UNDER && busMag <= underV_q) |=> !manualPermit)
      else $error("undervoltage did not block permit");
   chk_dead_line_permit: assert property (
      (syncEnable && lineDeadW && busLiveW && manEn[EN_DLLB] && !voltage_sensor_failure) |=> manualPermit)
      else $error("dead line permit withheld");
   chk_external_immediate: assert property (
      (immediateOn && external_sync_ok_input && !voltage_sensor_failure) |=> arImmediateOk)
      else $error("external sync did not allow immediate reclose");
   chk_paths_separate: assert property (
      (syncEnable && manEn == 4'h0 && arEn[EN_CS] && syncOk && !voltage_sensor_failure)
      |=> !manualPermit && arSysCheckOk) else $error("manual and reclose paths not separate");
   chk_bus_live_dead: assert property (
      busLive |-> !busDead || (liveV_q < deadV_q)) else $error("bus both live and dead");
endmodule // check_sync_reclose_permit

// ===== testbench/close_partner.sv
// Partner model: manual close control and external system check device
`timescale 1ns/1ps
module close_partner (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic closeCmd,
   input wire logic holdCmd,
   input wire logic extSyncIn,
   input wire logic extSysIn,
   input wire logic manualCloseGo,
   output logic manualCloseReq,
   output logic external_sync_ok_input,
   output logic externalSysCheckOk,
   output int goCount
);
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         manualCloseReq <= 1'b0;
         goCount <= 0;
      end else begin
         // One pulse per command; held only when a scenario asks for a stuck request
         manualCloseReq <= closeCmd | (holdCmd & manualCloseReq);
         if (manualCloseGo)
            goCount <= goCount + 1;
      end
   end
   assign external_sync_ok_input = extSyncIn;
   assign externalSysCheckOk = extSysIn;
endmodule // close_partner

// ===== testbench/test_check_sync_reclose_permit.sv
// Self-checking bench for the check-synchronism permit block
`timescale 1ns/1ps
module test_check_sync_reclose_permit;
   import sync_check_pkg::*;
   localparam int MAGS[8] = '{0, 129, 130, 319, 320, 540, 541, 900};
   logic sys_clk, nrst, regWrite, regRead, syncCheckEnableIn, sensorFail, closeCmd, holdCmd;
   logic extSyncIn, extSysIn, manualCloseReq, extSync, extSys, manualPermit, manualCloseGo;
   logic arSysCheckOk, arImmediateOk, lineLive, lineDead, busLive, busDead;
   logic [7:0] regAddr;
   logic [31:0] regWrData, regRdData;
   logic [5:0][15:0] mainMag;
   logic [5:0][11:0] mainAng;
   logic [15:0] checkMag, slipMeas;
   logic [11:0] checkAng;
   int goCount, numErrors, cmpCount, r;
   int ctrlM, angT, uvT, dvT, slipT, liveT, deadT;
   bit timeOk;

   check_sync_reclose_permit #(.STEP_CYCLES(4)) check_sync_reclose_permit_i (.sys_clk(sys_clk), .nrst(nrst),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .mainMag(mainMag), .mainAng(mainAng), .checkMag(checkMag), .checkAng(checkAng), .slipMeas(slipMeas),
      .syncCheckEnableIn(syncCheckEnableIn), .voltage_sensor_failure(sensorFail), .manualCloseReq(manualCloseReq),
      .external_sync_ok_input(extSync), .externalSysCheckOk(extSys), .manualPermit(manualPermit),
      .manualCloseGo(manualCloseGo), .arSysCheckOk(arSysCheckOk), .arImmediateOk(arImmediateOk),
      .lineLive(lineLive), .lineDead(lineDead), .busLive(busLive), .busDead(busDead));
   close_partner close_partner_i (.sys_clk(sys_clk), .nrst(nrst), .closeCmd(closeCmd), .holdCmd(holdCmd),
      .extSyncIn(extSyncIn), .extSysIn(extSysIn), .manualCloseGo(manualCloseGo), .manualCloseReq(manualCloseReq),
      .external_sync_ok_input(extSync), .externalSysCheckOk(extSys), .goCount(goCount));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // ---------------------------------------------------------------
   // Reference model: returns {busDead, busLive, lineDead, lineLive, arImm, arSys, manual}
   // ---------------------------------------------------------------
   function automatic logic [6:0] model();
      int code, mA, lM, bM, d;
      bit ll, ld, bl, bd, sy, sEn, mp, ars, arim;
      logic [31:0] c;
      c = ctrlM;
      code = c[4:2];
      if (code > 5)
         code = 0;
      mA = $signed(mainAng[code]);
      lM = c[1] ? checkMag : mainMag[code];
      bM = c[1] ? mainMag[code] : checkMag;
      ll = lM >= liveT;
      ld = lM < deadT;
      bl = bM >= liveT;
      bd = bM < deadT;
      d = mA - $signed(checkAng);
      if (d < 0)
         d = -d;
      if (d > 1800)
         d = 3600 - d;
      sy = ll && bl && d < angT && (!c[5] || (lM > uvT && bM > uvT))
         && (!c[6] || (lM > bM ? lM - bM : bM - lM) < dvT) && (!c[8] || slipMeas < slipT) && (!c[7] || timeOk);
      sEn = c[0] && syncCheckEnableIn;
      mp = !sensorFail && (!sEn || (c[10] && sy) || (c[11] && ld && bl) || (c[12] && ll && bd) || (c[13] && ld && bd));
      ars = !sensorFail && (!sEn || extSysIn || (c[14] && sy) || (c[15] && ld && bl) || (c[16] && ll && bd)
         || (c[17] && ld && bd));
      arim = !sensorFail && c[9] && ((sEn && c[14] && sy) || extSyncIn);
      return {bd, bl, ld, ll, arim, ars, mp};
   endfunction

   task automatic chkBit(string what, logic e, logic g);
      cmpCount++;
      if (g !== e) begin
         numErrors++;
         $display("unexpected %s: expected %b, seen %b", what, e, g);
      end
   endtask

   task automatic chkWord(string what, logic [31:0] e, logic [31:0] g);
      cmpCount++;
      if (g !== e) begin
         numErrors++;
         $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
   endtask

   task automatic chkAll();
      logic [6:0] e;
      e = model();
      chkBit("arImmediateOk", e[2], arImmediateOk);
      chkBit("manualPermit", e[0], manualPermit);
      chkBit("arSysCheckOk", e[1], arSysCheckOk);
      chkBit("lineLive", e[3], lineLive);
      chkBit("lineDead", e[4], lineDead);
      chkBit("busLive", e[5], busLive);
      chkBit("busDead", e[6], busDead);
   endtask

   task automatic wr(logic [7:0] a, int d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge sys_clk);
      regWrite <= 1'b0;
      case (a)
         OFS_CTRL: ctrlM = d;
         OFS_SLIPT: r = d;
         default: r = d;
      endcase
   endtask

   task automatic rdChk(logic [7:0] a, logic [31:0] e);
      @(posedge sys_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge sys_clk);
      regRead <= 1'b0;
      #1;
      chkWord("regRdData", e, regRdData);
   endtask

   task automatic run(int n, bit t);
      repeat (n) @(posedge sys_clk);
      #1;
      timeOk = t;
      chkAll();
   endtask

   task automatic setIn(int ang, int slip);
      @(posedge sys_clk);
      checkAng <= ang[11:0];
      slipMeas <= slip[15:0];
   endtask

   task automatic endSim();
      if (numErrors == 0 && cmpCount > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      numErrors++;
      endSim();
   end

   initial begin
      {nrst, regWrite, regRead, syncCheckEnableIn, sensorFail, closeCmd, holdCmd, extSyncIn, extSysIn} = '0;
      {regAddr, regWrData, checkAng} = '0;
      mainMag = {6{16'd600}};
      mainAng = '0;
      checkMag = 16'd600;
      slipMeas = 16'd10;
      ctrlM = CTRL_RESET;
      {angT, uvT, dvT, slipT, liveT, deadT} = {32'd200, 32'd540, 32'd65, 32'd50, 32'd320, 32'd130};
      timeOk = 1'b0;
      numErrors = 0;
      cmpCount = 0;
      void'($urandom(32'h7456d408));
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      rdChk(OFS_CTRL, CTRL_RESET);
      rdChk(OFS_ANGLE, {16'h0000, ANGLE_RESET});
      rdChk(8'h44, 32'h00000000);
      for (int i = 0; i < 240; i++) begin
         if (i % 8 == 0)
            wr(OFS_CTRL, $urandom & 32'h0003ff7f);
         @(posedge sys_clk);
         for (int k = 0; k < 6; k++) begin
            r = $urandom_range(600) - 300;
            mainAng[k] <= r[11:0];
            mainMag[k] <= 16'(MAGS[$urandom_range(7)]);
         end
         r = $urandom_range(600) - 300;
         checkAng <= r[11:0];
         checkMag <= 16'(MAGS[$urandom_range(7)]);
         slipMeas <= 16'($urandom_range(100));
         syncCheckEnableIn <= $urandom_range(3) != 0;
         sensorFail <= $urandom_range(7) == 0;
         extSyncIn <= 1'($urandom_range(1));
         extSysIn <= 1'($urandom_range(1));
         run(2, 0);
      end
      rdChk(OFS_CHKMAG, {16'h0000, checkMag});
      rdChk(OFS_SLIPMEAS, {16'h0000, slipMeas});
      // Nominal both-live conditions, then the timed slip modes
      @(posedge sys_clk);
      {sensorFail, extSyncIn, extSysIn, syncCheckEnableIn} <= 4'b0001;
      mainMag <= {6{16'd600}};
      mainAng <= '0;
      checkMag <= 16'd600;
      setIn(500, 10);
      wr(OFS_SLIPT, 3);
      wr(OFS_CTRL, 32'h00000481);
      setIn(10, 10);
      run(5, 0);
      run(14, 1);
      setIn(500, 10);
      setIn(10, 10);
      run(2, 0);
      wr(OFS_CTRL, 32'h00000581);
      setIn(10, 60);
      run(20, 1);
      setIn(10, 10);
      run(20, 1);
      wr(OFS_SLIPT, 6);
      wr(OFS_CTRL, 32'h00000481);
      setIn(500, 10);
      setIn(10, 10);
      run(16, 0);
      run(12, 1);
      // Frequency mode, close pulses and the immediate option
      wr(OFS_CTRL, 32'h00004701);
      run(2, 0);
      @(posedge sys_clk);
      closeCmd <= 1'b1;
      holdCmd <= 1'b1;
      @(posedge sys_clk);
      closeCmd <= 1'b0;
      run(10, 0);
      chkWord("goCount", 32'd1, goCount);
      setIn(10, 60);
      holdCmd <= 1'b0;
      extSyncIn <= 1'b1;
      extSysIn <= 1'b1;
      run(2, 0);
      // A pulse while the permit is withheld must not close later on its own
      @(posedge sys_clk);
      closeCmd <= 1'b1;
      @(posedge sys_clk);
      closeCmd <= 1'b0;
      run(3, 0);
      setIn(10, 10);
      run(4, 0);
      chkWord("goCount", 32'd1, goCount);
      // Dead line with live bus, differing enable sets
      @(posedge sys_clk);
      mainMag[0] <= 16'd50;
      wr(OFS_CTRL, 32'h00008901);
      run(2, 0);
      wr(OFS_CTRL, 32'h00008501);
      run(2, 0);
      wr(OFS_CTRL, 32'h00008502);
      run(2, 0);
      wr(OFS_CTRL, 32'h00000000);
      run(2, 0);
      @(posedge sys_clk);
      sensorFail <= 1'b1;
      run(2, 0);
      setIn(-20, 10);
      rdChk(OFS_CHKANG, 32'h00000fec);
      rdChk(OFS_ANGDIFF, 32'hffffffec);
      rdChk(OFS_STATUS, 32'h00000006);
      endSim();
   end
endmodule // test_check_sync_reclose_permit
